/* rtl/rpm_mux.sv */
// two multi-function pins: irq, gpio, rx clock, adc trigger, frame start
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module rpm_mux
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pccard_strap,
	input wire logic recovered_rx_clock,
	input wire logic rx_clock_input,
	input wire logic isa_irq_a,
	input wire logic isa_irq_b,
	input wire logic pin_a_in,
	output logic pin_a_out,
	output logic pin_a_oe,
	input wire logic pin_b_in,
	output logic pin_b_out,
	output logic pin_b_oe,
	input wire logic ext_chbsy_pin,
	input wire logic int_chbsy,
	output logic chbsy_status,
	input wire logic antenna_selected,
	input wire logic int_adc_start,
	output logic adc_start,
	output logic rx_fifo_load_enable,
	output logic irq
);
	logic [rpm_pkg::CTL_W-1:0] ctl_q;
	logic [rpm_pkg::DAT_W-1:0] dat_q;
	logic [rpm_pkg::ST_W-1:0] st_q;
	logic [rpm_pkg::ST_W-1:0] st_d;
	logic [rpm_pkg::ST_W-1:0] mask_q;
	logic [rpm_pkg::IRQ_W-1:0] irqcfg_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic pccard_q;
	logic strap_done_q;
	logic adc_start_q;
	logic chbsy_q;
	logic rx_load_q;
	logic adc_lvl;
	logic adc_rise;
	logic pb_lvl;
	logic pb_rise_unused;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic isa_mode;
	logic [3:0] irq_sel;
	logic [3:0] irq_typ;
	logic irq_for_a;
	logic irq_for_b;
	logic rx_clk_src;
	logic frame_start_flag;
	logic ext_frame_start_enable;
	logic ext_channel_busy_enable;
	logic ext_adc_start_enable;

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign addr_ok = (paddr == rpm_pkg::ADDR_CTRL) || (paddr == rpm_pkg::ADDR_DATA)
		|| (paddr == rpm_pkg::ADDR_STAT) || (paddr == rpm_pkg::ADDR_MASK)
		|| (paddr == rpm_pkg::ADDR_LEVEL) || (paddr == rpm_pkg::ADDR_IRQ);

	// strap is captured on the first clock after release, not by the reset itself
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pccard_q <= 1'b0;
			strap_done_q <= 1'b0;
		end
		else if (!strap_done_q)
		begin
			pccard_q <= pccard_strap;
			strap_done_q <= 1'b1;
		end
	end

	assign isa_mode = ~pccard_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctl_q <= rpm_pkg::CTL_RESET;
		else if (wr_en && paddr == rpm_pkg::ADDR_CTRL)
			ctl_q <= pwdata[rpm_pkg::CTL_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dat_q <= '0;
		else if (wr_en && paddr == rpm_pkg::ADDR_DATA)
			dat_q <= pwdata[rpm_pkg::DAT_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_q <= rpm_pkg::MASK_RESET;
		else if (wr_en && paddr == rpm_pkg::ADDR_MASK)
			mask_q <= pwdata[rpm_pkg::ST_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irqcfg_q <= rpm_pkg::IRQ_RESET;
		else if (wr_en && paddr == rpm_pkg::ADDR_IRQ)
			irqcfg_q <= pwdata[rpm_pkg::IRQ_W-1:0];
	end

	assign ext_adc_start_enable = ctl_q[rpm_pkg::CTL_ADC_EN];
	assign ext_frame_start_enable = ctl_q[rpm_pkg::CTL_SDF_EN];
	assign ext_channel_busy_enable = ctl_q[rpm_pkg::CTL_CHB_EN];
	assign irq_sel = irqcfg_q[rpm_pkg::IRQ_SEL_LSB +: 4];
	assign irq_typ = irqcfg_q[rpm_pkg::IRQ_TYP_LSB +: 4];

	// pin A
	assign rx_clk_src = ctl_q[rpm_pkg::CTL_RXC_SRC] ? rx_clock_input
		: recovered_rx_clock;
	assign irq_for_a = isa_mode && !ctl_q[rpm_pkg::CTL_RXC_SEL]
		&& irq_sel == rpm_pkg::IRQ_SEL_A;

	always_comb
	begin
		pin_a_out = 1'b0;
		pin_a_oe = 1'b0;
		if (ctl_q[rpm_pkg::CTL_RXC_SEL])
		begin
			pin_a_out = rx_clk_src;
			pin_a_oe = 1'b1;
		end
		else if (irq_for_a)
		begin
			// open drain drives only the low level; other types fall back to totem
			if (irq_typ == rpm_pkg::IRQ_TYP_OD)
			begin
				pin_a_out = 1'b0;
				pin_a_oe = ~isa_irq_a;
			end
			else
			begin
				pin_a_out = isa_irq_a;
				pin_a_oe = 1'b1;
			end
		end
		else if (ctl_q[rpm_pkg::CTL_A_OE])
		begin
			pin_a_out = dat_q[rpm_pkg::PIN_A];
			pin_a_oe = 1'b1;
		end
	end

	// pin B
	assign irq_for_b = isa_mode && !ext_frame_start_enable
		&& !ctl_q[rpm_pkg::CTL_B_FN] && irq_sel == rpm_pkg::IRQ_SEL_B;

	always_comb
	begin
		pin_b_out = 1'b0;
		pin_b_oe = 1'b0;
		if (ext_frame_start_enable)
		begin
			pin_b_out = 1'b0;
			pin_b_oe = 1'b0;
		end
		else if (irq_for_b)
		begin
			if (irq_typ == rpm_pkg::IRQ_TYP_OD)
			begin
				pin_b_out = 1'b0;
				pin_b_oe = ~isa_irq_b;
			end
			else
			begin
				pin_b_out = isa_irq_b;
				pin_b_oe = 1'b1;
			end
		end
		else if (ctl_q[rpm_pkg::CTL_B_OE])
		begin
			pin_b_out = dat_q[rpm_pkg::PIN_B];
			pin_b_oe = 1'b1;
		end
	end

	// pin A trigger and pin B level cross through synchronisers
	rpm_sync u_sync_a
	(
		.pclk(pclk),
		.presetn(presetn),
		.d(pin_a_in),
		.q(adc_lvl),
		.rise(adc_rise)
	);

	rpm_sync u_sync_b
	(
		.pclk(pclk),
		.presetn(presetn),
		.d(pin_b_in),
		.q(pb_lvl),
		.rise(pb_rise_unused)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			adc_start_q <= 1'b0;
		else
			adc_start_q <= int_adc_start | (ext_adc_start_enable & adc_rise);
	end

	assign adc_start = adc_start_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_load_q <= 1'b0;
		else
			rx_load_q <= ext_frame_start_enable && ext_channel_busy_enable
				&& (!ctl_q[rpm_pkg::CTL_ANT_REQ] || antenna_selected)
				&& ctl_q[rpm_pkg::CTL_RXS] && pb_lvl;
	end

	assign rx_fifo_load_enable = rx_load_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			chbsy_q <= 1'b0;
		else
			chbsy_q <= ext_channel_busy_enable ? ext_chbsy_pin : int_chbsy;
	end

	assign chbsy_status = chbsy_q;
	assign frame_start_flag = ext_frame_start_enable & pb_lvl;

	// sticky status: a set in the read cycle survives the clear
	always_comb
	begin
		st_d = st_q;
		if (rd_en && paddr == rpm_pkg::ADDR_STAT)
			st_d = '0;
		if (frame_start_flag)
			st_d[rpm_pkg::ST_SDF] = 1'b1;
		if (ext_adc_start_enable && adc_rise)
			st_d[rpm_pkg::ST_ADC] = 1'b1;
		if (chbsy_q)
			st_d[rpm_pkg::ST_CHB] = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign irq = |(st_q & mask_q);

	// read data registered at the setup edge; level reads pins live
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pslverr_q <= ~addr_ok;
			unique case (paddr)
				rpm_pkg::ADDR_CTRL: prdata_q <= {22'h0, ctl_q};
				rpm_pkg::ADDR_DATA: prdata_q <= {30'h0, dat_q};
				rpm_pkg::ADDR_STAT: prdata_q <= {29'h0, st_q | st_d};
				rpm_pkg::ADDR_MASK: prdata_q <= {29'h0, mask_q};
				rpm_pkg::ADDR_LEVEL: prdata_q <= {30'h0, pin_b_in, pin_a_in};
				rpm_pkg::ADDR_IRQ: prdata_q <= {24'h0, irqcfg_q};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign pready = psel & penable;
	// ties the unused edge output so it is read
	logic unused_ok;
	assign unused_ok = pb_rise_unused & adc_lvl;
endmodule : rpm_mux

/* rtl/rpm_pkg.sv */
// constants, register map and carrier types for the two-pin function mux
package rpm_pkg;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_DATA = 12'h004;
	localparam logic [11:0] ADDR_STAT = 12'h008;
	localparam logic [11:0] ADDR_MASK = 12'h00c;
	localparam logic [11:0] ADDR_LEVEL = 12'h010;
	localparam logic [11:0] ADDR_IRQ = 12'h014;
	// control register fields
	localparam int CTL_RXC_SEL = 0;
	localparam int CTL_RXC_SRC = 1;
	localparam int CTL_A_OE = 2;
	localparam int CTL_ADC_EN = 3;
	localparam int CTL_SDF_EN = 4;
	localparam int CTL_CHB_EN = 5;
	localparam int CTL_B_FN = 6;
	localparam int CTL_B_OE = 7;
	localparam int CTL_ANT_REQ = 8;
	localparam int CTL_RXS = 9;
	localparam int CTL_W = 10;
	// data / level register fields
	localparam int PIN_A = 0;
	localparam int PIN_B = 1;
	localparam int DAT_W = 2;
	// status / mask fields
	localparam int ST_SDF = 0;
	localparam int ST_ADC = 1;
	localparam int ST_CHB = 2;
	localparam int ST_W = 3;
	// irq select/type fields
	localparam int IRQ_SEL_LSB = 0;
	localparam int IRQ_TYP_LSB = 4;
	localparam int IRQ_W = 8;
	localparam logic [3:0] IRQ_SEL_A = 4'ha;
	localparam logic [3:0] IRQ_SEL_B = 4'h5;
	localparam logic [3:0] IRQ_TYP_TOTEM = 4'h2;
	localparam logic [3:0] IRQ_TYP_OD = 4'h1;
	localparam logic [CTL_W-1:0] CTL_RESET = 10'h000;
	localparam logic [ST_W-1:0] MASK_RESET = 3'h0;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 8'h00;
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic in;
		logic out;
		logic oe;
	} rpm_pin_s;

	typedef struct packed {
		logic isa_irq;
		logic rxc_sel;
		logic user_oe;
		logic data;
	} rpm_pin_cfg_s;
endpackage : rpm_pkg

/* rtl/rpm_sync.sv */
// two-stage synchroniser with combinational rising-edge pulse
`timescale 1ns/10ps
module rpm_sync
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic d,
	output logic q,
	output logic rise
);
	logic [rpm_pkg::SYNC_STAGES-1:0] sync_q;
	logic prev_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sync_q <= '0;
		else
			sync_q <= {sync_q[rpm_pkg::SYNC_STAGES-2:0], d};
	end

	// only the last stage feeds the edge detector
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_q <= 1'b0;
		else
			prev_q <= sync_q[rpm_pkg::SYNC_STAGES-1];
	end

	assign q = sync_q[rpm_pkg::SYNC_STAGES-1];
	assign rise = q & ~prev_q;
endmodule : rpm_sync

/* test/rpm_far.sv */
// outside circuitry on one pin: drives it whenever the mux lets go
`timescale 1ns/10ps
module rpm_far
(
	input wire logic oe,
	input wire logic out,
	input wire logic ext,
	output logic lvl
);
	// released pin shows the outside level, not the last driven one
	assign lvl = oe ? out : ext;
endmodule : rpm_far

/* test/rpm_properties.sv */
// port-level assertions for the two-pin function mux
`timescale 1ns/10ps
module rpm_properties
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pin_a_in,
	input wire logic pin_b_in,
	input wire logic pin_a_oe,
	input wire logic pin_b_oe,
	input wire logic ext_chbsy_pin,
	input wire logic int_chbsy,
	input wire logic chbsy_status,
	input wire logic int_adc_start,
	input wire logic adc_start,
	input wire logic irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic setup;
	assign setup = psel && !penable;
	rst_idle_a: assert property ($rose(presetn) |-> !pin_a_oe && !pin_b_oe && !irq)
		else $error("pin driven straight after reset");
	ready_now_a: assert property (pready == (psel && penable))
		else $error("pready not in access cycle");
	bad_addr_a: assert property (setup && paddr > 12'h014 |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	level_pa_a: assert property (setup && !pwrite && paddr == 12'h010 |=>
		prdata[0] == $past(pin_a_in)) else $error("pin a level wrong");
	level_pb_a: assert property (setup && !pwrite && paddr == 12'h010 |=>
		prdata[1] == $past(pin_b_in)) else $error("pin b level wrong");
	adc_int_a: assert property (int_adc_start |=> adc_start)
		else $error("internal start lost");
	adc_pulse_a: assert property (adc_start && !$past(int_adc_start) && !int_adc_start
		|=> !adc_start)
		else $error("start pulse too long");
	chbsy_src_a: assert property ($past(presetn) && $past(ext_chbsy_pin) == $past(int_chbsy)
		|-> chbsy_status == $past(int_chbsy)) else $error("busy status wrong");
	cover property (setup && !pwrite && paddr == 12'h008);
	cover property (adc_start && !int_adc_start);
	cover property (irq);
endmodule : rpm_properties

/* test/tb_rx_clock_irq_pin_mux.sv */
// self-checking bench for the two-pin function mux
`timescale 1ns/10ps
module tb_rx_clock_irq_pin_mux;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0, penable = 0, pwrite = 0, probe = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, e;
	logic pready, pslverr, strap = 0, ia = 0, ib = 0, ea = 0, eb = 0, ant = 0;
	logic pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, chb_st, adc, fifo, irq;
	logic chb_pin = 0, chb_int = 0, iadc = 0;
	logic [31:0] q[$];
	integer seed = 76483;
	int fails = 0, compares = 0, i, n;
	// ctrl[31:20] irqcfg[19:12] irq levels[9:8] pins[3:0]
	logic [31:0] rows [12] = '{32'h0032a20c, 32'h00100008, 32'h0002a20c, 32'h0001a200,
		32'h0001a008, 32'h0840000f, 32'h00000000, 32'h00025103, 32'h00015100,
		32'h00015002, 32'h0c025003, 32'h0940000c};
	always #10 pclk = ~pclk;
	rpm_mux DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pccard_strap(strap), .recovered_rx_clock(1'b0),
		.rx_clock_input(1'b1), .isa_irq_a(ia), .isa_irq_b(ib), .pin_a_in(pa_in),
		.pin_a_out(pa_out), .pin_a_oe(pa_oe), .pin_b_in(pb_in), .pin_b_out(pb_out),
		.pin_b_oe(pb_oe), .ext_chbsy_pin(chb_pin), .int_chbsy(chb_int),
		.chbsy_status(chb_st), .antenna_selected(ant), .int_adc_start(iadc),
		.adc_start(adc), .rx_fifo_load_enable(fifo), .irq(irq));
	rpm_far far_a (.oe(pa_oe), .out(pa_out), .ext(ea), .lvl(pa_in));
	rpm_far far_b (.oe(pb_oe), .out(pb_out), .ext(eb), .lvl(pb_in));
	always @(posedge pclk)
	begin
		iadc <= ($random(seed) % 8) == 0;
	end
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite)
			cmp(prdata);
		else if (probe)
			cmp({26'h0, fifo, irq, pa_oe, pa_out & pa_oe, pb_oe, pb_out & pb_oe});
	task automatic cmp(input logic [31:0] got);
		e = q.pop_front();
		compares++;
		if (got !== e)
		begin
			fails++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, e);
		end
	endtask : cmp
	task automatic results();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do
			@(posedge pclk);
		while (!pready && ++n < 50);
		if (n >= 50)
		begin
			fails++;
			results();
		end
		psel <= 0;
		penable <= 0;
		// one idle edge so the next call never reassigns psel in this step
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		q.push_back(x);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic look(input logic [31:0] x);
		q.push_back(x);
		probe <= 1;
		@(posedge pclk);
		probe <= 0;
		@(posedge pclk);
	endtask : look
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		for (i = 0; i < 7; i++)
			rd(12'(i * 4), 32'h0);
		chb_pin <= 1;
		apb(1'b1, rpm_pkg::ADDR_CTRL, 32'h20);
		rd(rpm_pkg::ADDR_STAT, 32'h4);
		apb(1'b1, rpm_pkg::ADDR_CTRL, 32'h0);
		chb_pin <= 0;
		rd(rpm_pkg::ADDR_STAT, 32'h4);
		rd(rpm_pkg::ADDR_STAT, 32'h0);
		apb(1'b1, rpm_pkg::ADDR_DATA, 32'h3);
		for (i = 0; i < 12; i++)
		begin
			ia <= rows[i][9];
			ib <= rows[i][8];
			ea <= 1'($random(seed));
			eb <= 1'($random(seed)) & ~rows[i][24];
			apb(1'b1, rpm_pkg::ADDR_IRQ, 32'(rows[i][19:12]));
			apb(1'b1, rpm_pkg::ADDR_CTRL, 32'(rows[i][31:20]));
			look(32'(rows[i][3:0]));
			rd(rpm_pkg::ADDR_LEVEL, {30'h0, (rows[i][1] ? rows[i][0] : eb),
				(rows[i][3] ? rows[i][2] : ea)});
		end
		ea <= 0;
		apb(1'b1, rpm_pkg::ADDR_MASK, 32'h3);
		apb(1'b1, rpm_pkg::ADDR_CTRL, 32'h18);
		eb <= 1;
		ea <= 1;
		repeat (5) @(posedge pclk);
		look(32'h10);
		eb <= 0;
		repeat (4) @(posedge pclk);
		rd(rpm_pkg::ADDR_STAT, 32'h3);
		rd(rpm_pkg::ADDR_STAT, 32'h0);
		look(32'h0);
		apb(1'b1, rpm_pkg::ADDR_MASK, 32'h0);
		apb(1'b1, rpm_pkg::ADDR_CTRL, 32'h330);
		eb <= 1;
		repeat (5) @(posedge pclk);
		look(32'h0);
		ant <= 1;
		repeat (5) @(posedge pclk);
		look(32'h20);
		rd(rpm_pkg::ADDR_STAT, 32'h1);
		presetn <= 0;
		strap <= 1;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		ia <= 1;
		apb(1'b1, rpm_pkg::ADDR_IRQ, 32'h2a);
		look(32'h0);
		apb(1'b1, rpm_pkg::ADDR_IRQ, 32'h25);
		look(32'h0);
		results();
	end
endmodule : tb_rx_clock_irq_pin_mux
bind rpm_mux rpm_properties chk (.*);
